// *** verilog/uecr_defs.svh ***
// register offsets, field positions and reset values of the endpoint/config block
`ifndef UECR_DEFS_SVH
`define UECR_DEFS_SVH
// ==========================================================
// register byte offsets
`define UECR_OFF_BASE_LOW   12'h000
`define UECR_OFF_BASE_MID   12'h004
`define UECR_OFF_BASE_TOP   12'h008
`define UECR_OFF_DBG_IDLE   12'h00C
`define UECR_OFF_IRQ_EN     12'h010
`define UECR_OFF_EP_BASE    12'h040
// ==========================================================
// field positions
`define UECR_BIT_EYE_TEST   7
`define UECR_BIT_DRV_MON    6
`define UECR_BIT_DBG_FRZ    5
`define UECR_BIT_IDLE_STOP  4
`define UECR_BIT_LS_DIRECT  7
`define UECR_BIT_NAK_RDIS   6
`define UECR_BIT_CTL_DIS    4
`define UECR_BIT_RX_EN      3
`define UECR_BIT_TX_EN      2
`define UECR_BIT_STALLED    1
`define UECR_BIT_HSHK_EN    0
`define UECR_BIT_MOD_IRQ    25
`define UECR_BASE_LOW_LSB   9
// ==========================================================
// reset values and masks
`define UECR_RST_BYTE       8'h00
`define UECR_LOW_MASK       8'hFE
`define UECR_DBG_MASK       8'hF0
`define UECR_EP_MASK        8'hDF
`endif

// *** verilog/uecr_pkg.sv ***
// types shared by the endpoint/config register block
package uecr_pkg;
    typedef logic [7:0] uecr_byte_type;
    typedef enum logic [1:0] {UECR_ACC_IDLE, UECR_ACC_READ, UECR_ACC_WRITE} uecr_acc_type;
endpackage : uecr_pkg

// *** verilog/uecr_top.sv ***
// endpoint control, table base and debug/idle config registers behind APB
// Overview of operation
// - mid byte gives table address 23:16
// - top byte gives table address 31:24
// - low field 7:1 gives address 15:9
// - table address low nine bits zero
// - bits 31:8 reserved, read zero, except irq enable bit 25
// - config bit 7 enables eye test
// - bit 6 shows line drive monitor
// - bit 5 freezes module under debug halt
// - freeze bit writable only in debug exception
// - bit 4 stops module in idle
// - ep0 bit 7 selects direct low speed in host mode
// - ep0 bit 6 disables nak retry
// - bit 4 refuses setup when bidirectional
// - bit 3 enables endpoint reception
// - bit 2 enables endpoint transmission
// - bit 1 reports endpoint stalled
// - bit 0 enables handshake packets
// - irq enable cleared on every reset
`timescale 1ns/1ns
`include "uecr_defs.svh"

module uecr_top
    import uecr_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NUM_EP = 16
) (
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [ADDR_W-1:0]   PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                HOST_MODE,
    input  wire logic                DEBUG_HALT,
    input  wire logic                DEBUG_EXC,
    input  wire logic                IDLE_MODE,
    input  wire logic                LINE_DRIVE,
    input  wire logic                MODULE_IRQ,
    input  wire logic [NUM_EP-1:0]   EP_STALL_SET,
    output logic      [31:0]         TABLE_BASE,
    output logic      [NUM_EP-1:0]   EP_RX_EN,
    output logic      [NUM_EP-1:0]   EP_TX_EN,
    output logic      [NUM_EP-1:0]   EP_SETUP_OK,
    output logic      [NUM_EP-1:0]   EP_HSHK_EN,
    output logic                     LOW_SPEED_DIRECT,
    output logic                     NAK_RETRY_EN,
    output logic                     MODULE_RUN,
    output logic                     DRIVE_MON,
    output logic                     EYE_DP,
    output logic                     EYE_DM,
    output logic                     EYE_OE,
    output logic                     IRQ_OUT
);

    // ==========================================================
    // state
    uecr_byte_type base_low_r;
    uecr_byte_type base_mid_r;
    uecr_byte_type base_top_r;
    uecr_byte_type dbg_cfg_r;
    logic          irq_en_r;
    uecr_byte_type ep_r [NUM_EP];
    logic [NUM_EP-1:0] stall_r;
    logic          eye_phase_r;
    logic [31:0]   prdata_r;

    // ==========================================================
    // bus decode
    uecr_acc_type  acc;
    logic          setup_ph;
    logic          hit_low;
    logic          hit_mid;
    logic          hit_top;
    logic          hit_dbg;
    logic          hit_irq;
    logic          hit_ep;
    logic          hit_any;
    logic [3:0]    ep_idx;
    uecr_byte_type wbyte;
    logic          wr_ok;

    // access kind taken in the access phase only
    assign acc      = !(PSEL && PENABLE) ? UECR_ACC_IDLE :
                      (PWRITE ? UECR_ACC_WRITE : UECR_ACC_READ);
    assign setup_ph = PSEL && !PENABLE;
    assign hit_low  = PADDR == ADDR_W'(`UECR_OFF_BASE_LOW);
    assign hit_mid  = PADDR == ADDR_W'(`UECR_OFF_BASE_MID);
    assign hit_top  = PADDR == ADDR_W'(`UECR_OFF_BASE_TOP);
    assign hit_dbg  = PADDR == ADDR_W'(`UECR_OFF_DBG_IDLE);
    assign hit_irq  = PADDR == ADDR_W'(`UECR_OFF_IRQ_EN);
    // endpoints occupy sixteen aligned words
    assign hit_ep   = (PADDR[ADDR_W-1:6] == (ADDR_W-6)'(ADDR_W'(`UECR_OFF_EP_BASE) >> 6)) && (PADDR[1:0] == 2'h0);
    assign ep_idx   = PADDR[5:2];
    assign hit_any  = hit_low | hit_mid | hit_top | hit_dbg | hit_irq | hit_ep;
    assign wbyte    = PWDATA[7:0];
    assign wr_ok    = (acc == UECR_ACC_WRITE) && hit_any;

    // zero wait states; unmapped words answer with an error
    assign PREADY  = 1'b1;
    assign PSLVERR = (acc != UECR_ACC_IDLE) && !hit_any;

    // ==========================================================
    // read mux
    uecr_byte_type rd_byte;
    uecr_byte_type ep_rd;

    // stall status comes from its own flop, not the stored byte
    assign ep_rd   = (ep_r[ep_idx] & ~(8'h01 << `UECR_BIT_STALLED))
                   | (uecr_byte_type'(stall_r[ep_idx]) << `UECR_BIT_STALLED);
    assign rd_byte = hit_low ? base_low_r :
                     hit_mid ? base_mid_r :
                     hit_top ? base_top_r :
                     hit_dbg ? dbg_cfg_r  :
                     hit_ep  ? ep_rd      : `UECR_RST_BYTE;

    // upper bits read zero, except irq enable bit 25
    // read data sampled in setup so it stands through the access phase
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            prdata_r <= 32'h0;
        end else if (setup_ph && !PWRITE) begin
            prdata_r <= hit_irq ? (32'h1 << `UECR_BIT_MOD_IRQ) & {32{irq_en_r}} : {24'h0, rd_byte};
        end
    end
    assign PRDATA = prdata_r;

    // ==========================================================
    // table base pointer bytes
    // reserved bit 0 of the low byte never stores
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            base_low_r <= `UECR_RST_BYTE;
            base_mid_r <= `UECR_RST_BYTE;
            base_top_r <= `UECR_RST_BYTE;
        end else if (wr_ok) begin
            if (hit_low) base_low_r <= wbyte & `UECR_LOW_MASK;
            if (hit_mid) base_mid_r <= wbyte;
            if (hit_top) base_top_r <= wbyte;
        end
    end

    assign TABLE_BASE = {base_top_r, base_mid_r, base_low_r[7:1], 9'h000};

    // ==========================================================
    // debug and idle configuration
    uecr_byte_type dbg_nxt;

    // freeze bit held at zero outside debug exception
    always_comb begin
        dbg_nxt = dbg_cfg_r;
        if (wr_ok && hit_dbg) begin
            dbg_nxt = wbyte & `UECR_DBG_MASK;
        end
        if (!DEBUG_EXC) begin
            dbg_nxt[`UECR_BIT_DBG_FRZ] = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            dbg_cfg_r <= `UECR_RST_BYTE;
        end else begin
            dbg_cfg_r <= dbg_nxt;
        end
    end

    assign MODULE_RUN = !(dbg_cfg_r[`UECR_BIT_DBG_FRZ] && DEBUG_HALT)
                      && !(dbg_cfg_r[`UECR_BIT_IDLE_STOP] && IDLE_MODE);

    // ==========================================================
    // eye pattern and drive monitor
    // phase flips every clock, cleared to zero when the module is halted or eye test is off
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            eye_phase_r <= 1'b0;
        end else if (dbg_cfg_r[`UECR_BIT_EYE_TEST] && MODULE_RUN) begin
            eye_phase_r <= !eye_phase_r;
        end else begin
            eye_phase_r <= 1'b0;
        end
    end

    // test drive enabled by config bit
    assign EYE_OE = dbg_cfg_r[`UECR_BIT_EYE_TEST];
    assign EYE_DP = eye_phase_r;
    assign EYE_DM = !eye_phase_r;

    // monitor follows real drive, including the eye test
    assign DRIVE_MON = dbg_cfg_r[`UECR_BIT_DRV_MON] && (LINE_DRIVE || EYE_OE);

    // ==========================================================
    // interrupt enable
    // cleared on reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_en_r <= 1'b0;
        end else if (wr_ok && hit_irq) begin
            irq_en_r <= PWDATA[`UECR_BIT_MOD_IRQ];
        end
    end

    assign IRQ_OUT = irq_en_r && MODULE_IRQ;

    // ==========================================================
    // endpoint control, one slice per endpoint
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            logic ep_wr;
            assign ep_wr = wr_ok && hit_ep && (ep_idx == 4'(g));

            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    ep_r[g] <= `UECR_RST_BYTE;
                end else if (ep_wr) begin
                    ep_r[g] <= wbyte & `UECR_EP_MASK;
                end
            end

            // hardware set wins over a software clear
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    stall_r[g] <= 1'b0;
                end else if (EP_STALL_SET[g]) begin
                    stall_r[g] <= 1'b1;
                end else if (ep_wr) begin
                    stall_r[g] <= wbyte[`UECR_BIT_STALLED];
                end
            end

            assign EP_RX_EN[g]    = ep_r[g][`UECR_BIT_RX_EN];
            assign EP_TX_EN[g]    = ep_r[g][`UECR_BIT_TX_EN];
            // setup refused only when both directions on
            assign EP_SETUP_OK[g] = !(EP_RX_EN[g] && EP_TX_EN[g] && ep_r[g][`UECR_BIT_CTL_DIS]);
            assign EP_HSHK_EN[g]  = ep_r[g][`UECR_BIT_HSHK_EN];
        end
    endgenerate

    // low speed direct, endpoint 0 in host mode only
    assign LOW_SPEED_DIRECT = HOST_MODE && ep_r[0][`UECR_BIT_LS_DIRECT];
    assign NAK_RETRY_EN     = HOST_MODE && !ep_r[0][`UECR_BIT_NAK_RDIS];

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    base_low_a: assert property (wr_ok && hit_low |=> TABLE_BASE[15:9] == $past(PWDATA[7:1]))
        else $error("low table field not applied");
    base_mid_a: assert property (wr_ok && hit_mid |=> TABLE_BASE[23:16] == $past(PWDATA[7:0]))
        else $error("mid table byte not applied");
    base_top_a: assert property (wr_ok && hit_top |=> TABLE_BASE[31:24] == $past(PWDATA[7:0]))
        else $error("top table byte not applied");
    base_align_a: assert property (TABLE_BASE[8:0] == 9'h000)
        else $error("table base not aligned");
    rsvd_zero_a: assert property (setup_ph && !PWRITE && !hit_irq |=> PRDATA[31:8] == 24'h0)
        else $error("reserved bits read nonzero");
    frz_force_a: assert property (!DEBUG_EXC |=> !dbg_cfg_r[`UECR_BIT_DBG_FRZ])
        else $error("freeze bit set outside debug exception");
    run_gate_a: assert property (dbg_cfg_r[`UECR_BIT_IDLE_STOP] && IDLE_MODE |-> !MODULE_RUN)
        else $error("module runs in idle with stop set");
    frz_halt_a: assert property (dbg_cfg_r[`UECR_BIT_DBG_FRZ] && DEBUG_HALT |-> !MODULE_RUN)
        else $error("module runs while frozen");
    eye_tog_a: assert property (EYE_OE && MODULE_RUN ##1 EYE_OE && MODULE_RUN |-> EYE_DP != $past(EYE_DP))
        else $error("eye pattern not alternating");
    stall_set_a: assert property (EP_STALL_SET != '0 |=> (stall_r & $past(EP_STALL_SET)) == $past(EP_STALL_SET))
        else $error("stall event lost");
    irq_gate_a: assert property (!irq_en_r |-> !IRQ_OUT)
        else $error("irq forwarded while disabled");
    // the reset check must run while reset is low, so it opts out of the default disable
    irq_rst_a: assert property (@(posedge CLK) disable iff (1'b0) !RST_N |=> !irq_en_r)
        else $error("irq enable not cleared by reset");

    // configuration writes show one edge after the access phase
    eye_en_a: assert property (wr_ok && hit_dbg |=> EYE_OE == $past(PWDATA[`UECR_BIT_EYE_TEST]))
        else $error("eye test enable not applied");
    idle_wr_a: assert property (wr_ok && hit_dbg |=>
        dbg_cfg_r[`UECR_BIT_IDLE_STOP] == $past(PWDATA[`UECR_BIT_IDLE_STOP]))
        else $error("idle stop bit not applied");
    frz_write_a: assert property (wr_ok && hit_dbg && DEBUG_EXC |=>
        dbg_cfg_r[`UECR_BIT_DBG_FRZ] == $past(PWDATA[`UECR_BIT_DBG_FRZ]))
        else $error("freeze bit write lost in debug exception");
    irq_wr_a: assert property (wr_ok && hit_irq |=> irq_en_r == $past(PWDATA[`UECR_BIT_MOD_IRQ]))
        else $error("irq enable write not applied");

    // output gating by the stored configuration
    mon_off_a: assert property (!dbg_cfg_r[`UECR_BIT_DRV_MON] |-> !DRIVE_MON)
        else $error("drive monitor active while disabled");
    mon_line_a: assert property (dbg_cfg_r[`UECR_BIT_DRV_MON] && LINE_DRIVE |-> DRIVE_MON)
        else $error("drive monitor misses line drive");
    eye_pair_a: assert property (EYE_OE |-> EYE_DM != EYE_DP)
        else $error("eye pattern lines not complementary");
    run_free_a: assert property (!dbg_cfg_r[`UECR_BIT_DBG_FRZ] &&
        !dbg_cfg_r[`UECR_BIT_IDLE_STOP] |-> MODULE_RUN)
        else $error("module stopped with freeze and idle stop clear");
    ls_host_a: assert property (!HOST_MODE |-> !LOW_SPEED_DIRECT)
        else $error("low speed direct outside host mode");
    retry_host_a: assert property (HOST_MODE |-> NAK_RETRY_EN == !ep_r[0][`UECR_BIT_NAK_RDIS])
        else $error("nak retry does not follow disable bit");
    irq_fwd_a: assert property (irq_en_r && MODULE_IRQ |-> IRQ_OUT)
        else $error("enabled irq not forwarded");

    // endpoint slices, checked through the index of the write
    ep_rx_a: assert property (wr_ok && hit_ep |=>
        EP_RX_EN[$past(ep_idx)] == $past(PWDATA[`UECR_BIT_RX_EN]))
        else $error("endpoint receive enable not applied");
    ep_tx_a: assert property (wr_ok && hit_ep |=>
        EP_TX_EN[$past(ep_idx)] == $past(PWDATA[`UECR_BIT_TX_EN]))
        else $error("endpoint transmit enable not applied");
    ep_hshk_a: assert property (wr_ok && hit_ep |=>
        EP_HSHK_EN[$past(ep_idx)] == $past(PWDATA[`UECR_BIT_HSHK_EN]))
        else $error("endpoint handshake enable not applied");
    setup_gate_a: assert property (wr_ok && hit_ep && PWDATA[`UECR_BIT_CTL_DIS] &&
        PWDATA[`UECR_BIT_RX_EN] && PWDATA[`UECR_BIT_TX_EN] |=> !EP_SETUP_OK[$past(ep_idx)])
        else $error("setup accepted with control disabled");
    setup_open_a: assert property (wr_ok && hit_ep && !PWDATA[`UECR_BIT_CTL_DIS] |=>
        EP_SETUP_OK[$past(ep_idx)])
        else $error("setup refused with control enabled");

    // stall flags move only on an event or a write; reserved irq bits read zero
    stall_hold_a: assert property (EP_STALL_SET == '0 && !(wr_ok && hit_ep) |=> $stable(stall_r))
        else $error("stall flag changed without cause");
    rsvd_irq_a: assert property (setup_ph && !PWRITE && hit_irq |=>
        PRDATA[31:26] == 6'h00 && PRDATA[24:0] == 25'h0)
        else $error("reserved irq enable bits read nonzero");

    ep_write_c: cover property (wr_ok && hit_ep ##1 EP_RX_EN != '0);
    stall_clr_c: cover property (EP_STALL_SET[0] && wr_ok && hit_ep && ep_idx == 4'h0);
    eye_run_c: cover property ((EYE_OE && MODULE_RUN) [*3]);
    frz_hold_c: cover property (dbg_cfg_r[`UECR_BIT_DBG_FRZ] && DEBUG_HALT);
    unmapped_c: cover property (PSLVERR);

endmodule : uecr_top

// *** verif/uecr_far_model.sv ***
// far-side model: stall events and line drive seen from the attached bus partner
`timescale 1ns/1ns
// ==========================================
// far side of the serial link
module uecr_far_model
    import uecr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        stall_req,
    input  wire logic [3:0]  stall_ep,
    input  wire logic        drive_req,
    output logic      [15:0] stall_set,
    output logic             line_drive
);
    // stall pulse registered from the request, one cycle late and held for as long as the request is held
    always_ff @(posedge clk) begin
        stall_set  <= stall_req ? (16'h0001 << stall_ep) : 16'h0000;
        line_drive <= drive_req;
    end
endmodule : uecr_far_model

// *** verif/uecr_top_tb_top.sv ***
// self-checking bench for the endpoint/config register block
`timescale 1ns/1ns
`include "uecr_defs.svh"
// ==========================================
// bench top
module uecr_top_tb_top
    import uecr_pkg::*;
;
    logic        CLK, RST_N, PSEL, PENABLE, PWRITE, HOST_MODE, DEBUG_HALT, DEBUG_EXC, IDLE_MODE, MODULE_IRQ;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, TABLE_BASE, q, d;
    logic        PREADY, PSLVERR, LINE_DRIVE, LOW_SPEED_DIRECT, NAK_RETRY_EN, MODULE_RUN, DRIVE_MON;
    logic        EYE_DP, EYE_DM, EYE_OE, IRQ_OUT, err, p, stall_req, drive_req;
    logic [15:0] EP_STALL_SET, EP_RX_EN, EP_TX_EN, EP_SETUP_OK, EP_HSHK_EN;
    logic [3:0]  stall_ep;
    int          error_cnt, compares, seed, m[5], ep_m[16];
    uecr_top #(.ADDR_W(12), .NUM_EP(16)) uecr_top_i (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .HOST_MODE(HOST_MODE), .DEBUG_HALT(DEBUG_HALT), .DEBUG_EXC(DEBUG_EXC), .IDLE_MODE(IDLE_MODE),
        .LINE_DRIVE(LINE_DRIVE), .MODULE_IRQ(MODULE_IRQ), .EP_STALL_SET(EP_STALL_SET), .TABLE_BASE(TABLE_BASE),
        .EP_RX_EN(EP_RX_EN), .EP_TX_EN(EP_TX_EN), .EP_SETUP_OK(EP_SETUP_OK), .EP_HSHK_EN(EP_HSHK_EN),
        .LOW_SPEED_DIRECT(LOW_SPEED_DIRECT), .NAK_RETRY_EN(NAK_RETRY_EN), .MODULE_RUN(MODULE_RUN),
        .DRIVE_MON(DRIVE_MON), .EYE_DP(EYE_DP), .EYE_DM(EYE_DM), .EYE_OE(EYE_OE), .IRQ_OUT(IRQ_OUT));
    uecr_far_model uecr_far_model_i (.clk(CLK), .stall_req(stall_req), .stall_ep(stall_ep),
        .drive_req(drive_req), .stall_set(EP_STALL_SET), .line_drive(LINE_DRIVE));
    // ==========================================
    // clock and hang guard
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial begin
        repeat (50000) @(posedge CLK);
        error_cnt++;
        close_out();
    end
    // ==========================================
    // helpers
    task automatic close_out;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge CLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (n == 16) begin
            error_cnt++;
            close_out();
        end
        q = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input int e);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", e, q);
    endtask : rd
    function automatic logic [11:0] ep_a(input int i);
        return 12'(`UECR_OFF_EP_BASE + 4 * i);
    endfunction : ep_a
    // ==========================================
    // main sequence
    initial begin
        {PSEL, PENABLE, PWRITE, HOST_MODE, DEBUG_HALT, DEBUG_EXC, IDLE_MODE, MODULE_IRQ} = '0;
        {stall_req, drive_req, stall_ep, PADDR, PWDATA, RST_N} = '0;
        seed = 32'hefc8;
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 5; i++) rd(12'(4 * i), 0);
        for (int i = 0; i < 16; i++) rd(ep_a(i), 0);
        // table base bytes; reserved bits kept zero as software must
        for (int i = 0; i < 3; i++) begin
            d = $random(seed) & ((i == 0) ? 32'hFE : 32'hFF);
            apb(1'b1, 12'(4 * i), d);
            m[i] = d & ((i == 0) ? 32'hFE : 32'hFF);
            rd(12'(4 * i), m[i]);
        end
        @(negedge CLK);
        chk("table_base", {m[2][7:0], m[1][7:0], m[0][7:1], 9'h000}, TABLE_BASE);
        // line drive monitor follows the far side only when enabled
        for (int k = 0; k < 4; k++) begin
            @(posedge CLK) drive_req <= k[0];
            apb(1'b1, `UECR_OFF_DBG_IDLE, k[1] ? 32'h40 : 32'h00);
            @(negedge CLK);
            chk("drive_mon", k[0] & k[1], DRIVE_MON);
        end
        @(posedge CLK) {drive_req, DEBUG_HALT} <= 2'b01;
        apb(1'b1, `UECR_OFF_DBG_IDLE, 32'hF0);
        rd(`UECR_OFF_DBG_IDLE, 32'hD0);
        @(negedge CLK);
        chk("run_nofrz", 1, MODULE_RUN);
        chk("eye_oe", 1, EYE_OE);
        chk("eye_dm", !EYE_DP, EYE_DM);
        p = EYE_DP;
        @(negedge CLK);
        chk("eye_dp", !p, EYE_DP);
        @(posedge CLK) DEBUG_EXC <= 1'b1;
        apb(1'b1, `UECR_OFF_DBG_IDLE, 32'hF0);
        rd(`UECR_OFF_DBG_IDLE, 32'hF0);
        @(negedge CLK);
        chk("run_frz", 0, MODULE_RUN);
        @(posedge CLK) {DEBUG_HALT, IDLE_MODE, DEBUG_EXC} <= 3'b010;
        @(negedge CLK);
        chk("run_idle", 0, MODULE_RUN);
        rd(`UECR_OFF_DBG_IDLE, 32'hD0);
        apb(1'b1, `UECR_OFF_DBG_IDLE, 32'h00);
        @(negedge CLK);
        chk("run_noidle", 1, MODULE_RUN);
        // endpoints; odd ones bidirectional so the setup refusal is reached
        for (int i = 0; i < 16; i++) begin
            d = ($random(seed) & 32'hDF) | (i[0] ? 32'h1C : 32'h00);
            apb(1'b1, ep_a(i), d);
            ep_m[i] = d & 32'hDF;
            rd(ep_a(i), ep_m[i]);
            @(negedge CLK);
            chk("ep_out", {ep_m[i][3], ep_m[i][2], ep_m[i][0], ~(ep_m[i][4] & ep_m[i][3] & ep_m[i][2])},
                {EP_RX_EN[i], EP_TX_EN[i], EP_HSHK_EN[i], EP_SETUP_OK[i]});
        end
        // host-only speed and retry selects on endpoint 0
        for (int k = 0; k < 4; k++) begin
            @(posedge CLK) HOST_MODE <= k[1];
            apb(1'b1, ep_a(0), k[0] ? 32'h80 : 32'h40);
            @(negedge CLK);
            chk("host", {k[1] & k[0], k[1] & k[0]}, {LOW_SPEED_DIRECT, NAK_RETRY_EN});
        end
        // stall report from the far side, then software clear
        apb(1'b1, ep_a(5), 32'h00);
        @(posedge CLK) {stall_req, stall_ep} <= {1'b1, 4'h5};
        @(posedge CLK) stall_req <= 1'b0;
        repeat (2) @(posedge CLK);
        rd(ep_a(5), 32'h02);
        apb(1'b1, ep_a(5), 32'h00);
        rd(ep_a(5), 32'h00);
        // stall event in the very cycle of a clearing write: the event wins
        fork
            apb(1'b1, ep_a(0), 32'h00);
            begin
                @(posedge CLK) {stall_req, stall_ep} <= {1'b1, 4'h0};
                @(posedge CLK) stall_req <= 1'b0;
            end
        join
        rd(ep_a(0), 32'h02);
        // interrupt gating and unmapped access
        @(posedge CLK) MODULE_IRQ <= 1'b1;
        @(negedge CLK);
        chk("irq_off", 0, IRQ_OUT);
        apb(1'b1, `UECR_OFF_IRQ_EN, 32'h0200_0000);
        rd(`UECR_OFF_IRQ_EN, 32'h0200_0000);
        @(negedge CLK);
        chk("irq_on", 1, IRQ_OUT);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk("slverr", 1, err);
        chk("unmapped_rd", 0, q);
        // second reset mid-run clears the interrupt enable
        @(posedge CLK) RST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rd(`UECR_OFF_IRQ_EN, 0);
        @(negedge CLK);
        chk("irq_rst", 0, IRQ_OUT);
        close_out();
    end
endmodule : uecr_top_tb_top
